// File: bench/asp_host_model.sv
// Host controller acting as serial master towards the converter port.
// Assumes the bench calls its tasks; sck line has a pull-up when undriven.
`default_nettype none

module asp_host_model (
    input  wire logic clock,
    input  wire logic sckOut,
    input  wire logic sckOe_n,
    input  wire logic sdoOut,
    output logic      csPin_n,
    output logic      sckIn,
    output logic      sdiPin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hostSck   = 1'b0;
    logic hostDrive = 1'b0;
    logic active    = 1'b0;
    logic sdiData   = 1'b0;
    logic junk      = 1'b0;
    int   tick      = 0;

    initial csPin_n = 1'b1;
    // Line levels: device drive wins, else host, else the pull-up
    assign sckIn  = !sckOe_n ? sckOut : (hostDrive ? hostSck : 1'b1);
    assign sdiPin = active ? sdiData : junk;
    // Idle data toggles so a stale level never passes for valid
    always @(posedge clock) begin
        junk <= ~junk;
        tick <= tick + 1;
    end

    // Clock held low before the select edge when external mode is wanted
    task automatic select(input logic ext);
        @(posedge clock);
        hostDrive <= ext;
        hostSck   <= 1'b0;
        repeat (4) @(posedge clock);
        csPin_n   <= 1'b0;
    endtask : select

    // Release may come mid-frame or after a read
    task automatic deselect();
        @(posedge clock);
        csPin_n <= 1'b1;
        repeat (4) @(posedge clock);
        hostDrive <= 1'b0;
    endtask : deselect

    // Shifts n bits; sdo taken just before each host rise or just after each device rise, period between last rises
    task automatic xfer(input int n, input logic [4:0] addr, output logic [20:0] got, output int period);
        int   t;
        int   lastRise;
        logic prev;
        got = '0;
        period = 0;
        lastRise = 0;
        active <= 1'b1;
        for (int i = 0; i < n; i++) begin
            sdiData <= (i < 5) ? addr[4-i] : junk;
            if (hostDrive) begin
                repeat (10) @(posedge clock);
                got = {got[19:0], sdoOut};
                hostSck <= 1'b1;
                repeat (10) @(posedge clock);
                hostSck <= 1'b0;
            end else begin
                // Device clock and data sampled mid-cycle, clear of the edge that launches them
                t = 0;
                @(negedge clock);
                prev = sckOut;
                @(negedge clock);
                while (t < 400 && !(sckOe_n === 1'b0 && sckOut === 1'b1 && prev === 1'b0)) begin
                    prev = sckOut;
                    @(negedge clock);
                    t++;
                end
                // A missing rise leaves an unknown bit, so the word compare fails
                got = {got[19:0], (t < 400) ? sdoOut : 1'bx};
                period = tick - lastRise;
                lastRise = tick;
                repeat (8) @(posedge clock);
            end
        end
        active <= 1'b0;
    endtask : xfer

endmodule : asp_host_model

`default_nettype wire

// File: bench/asp_serial_port_asserts.sv
// Checker for the converter serial port, bound to its top-level ports.
// Assumes one clock and synchronous active-high reset.
`default_nettype none

module asp_serial_port_asserts #(
    parameter int unsigned CONV_LEN = 400,
    parameter int unsigned ADDR_W   = 5
) (
    input wire logic                            clock,
    input wire logic                            rst,
    input wire logic                            csPin_n,
    input wire logic                            sckIn,
    input wire logic                            sckOut,
    input wire logic                            sckOe_n,
    input wire logic                            sdiPin,
    input wire logic                            sdoOut,
    input wire logic                            sdoOe_n,
    input wire logic [asp_pkg::RESULT_BITS-1:0] resultIn,
    input wire logic [ADDR_W-1:0]               channel,
    input wire logic                            convBusy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // =====================================================================
    // Sequences
    // Selected and busy; pin term masks the sync lag after a release
    sequence s_busy_shown;
        (!csPin_n && !sdoOe_n && convBusy)[*3];
    endsequence
    // Low half of the internal serial clock after its first low cycle, fifteen system clocks
    sequence s_half_low;
        (!sckOut || csPin_n)[*8] ##1 (!sckOut || csPin_n)[*7];
    endsequence

    // =====================================================================
    // Properties
    a_sdo_release: assert property (csPin_n[*5] |-> sdoOe_n)
        else $error("sdo driven while deselected");
    a_sdo_select: assert property ((!csPin_n)[*6] |-> !sdoOe_n)
        else $error("sdo not driven while selected");
    a_busy_flag: assert property (s_busy_shown |-> sdoOut)
        else $error("busy flag missing on sdo");
    a_done_flag: assert property ($fell(convBusy) && !sdoOe_n && !csPin_n |-> ##[0:2] !sdoOut)
        else $error("done flag missing on sdo");
    a_chan_commit: assert property ($changed(channel) |-> !$past(convBusy, 3) ##[0:2] convBusy)
        else $error("channel changed outside frame end");
    a_sck_quiet: assert property ((convBusy || csPin_n)[*6] |-> sckOe_n)
        else $error("sck driven outside data output");
    a_sck_half: assert property ($fell(sckOut) && !sckOe_n |-> ##1 s_half_low ##1 (sckOut || csPin_n))
        else $error("internal sck half period wrong");
    a_frame_end: assert property ($rose(convBusy) && !sdoOe_n && !csPin_n |-> ##[0:1] sdoOut)
        else $error("sdo not high at conversion start");
    a_sleep_hold: assert property ((!convBusy && csPin_n)[*8] |=> !convBusy)
        else $error("sleep left while deselected");

endmodule : asp_serial_port_asserts

bind asp_serial_port asp_serial_port_asserts #(.CONV_LEN(CONV_LEN), .ADDR_W(ADDR_W)) i_asserts (
    .clock(clock), .rst(rst), .csPin_n(csPin_n), .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n),
    .sdiPin(sdiPin), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .resultIn(resultIn), .channel(channel),
    .convBusy(convBusy)
);

`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the converter serial port with a host model.
// Assumes a shortened conversion set through CONV_LEN.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned CONV    = 80;
    localparam int unsigned SCK_PER = asp_pkg::SCK_DIV * asp_pkg::CCLK_DIV;
    logic        clock;
    logic        rst;
    logic        csPin_n;
    logic        sckIn;
    logic        sckOut;
    logic        sckOe_n;
    logic        sdiPin;
    logic        sdoOut;
    logic        sdoOe_n;
    logic        convBusy;
    logic [17:0] resultIn;
    logic [4:0]  channel;
    logic [20:0] got;
    int          per;
    int          n_fail    = 0;
    int          cmp_count = 0;

    asp_serial_port #(.CONV_LEN(CONV)) i_dut (
        .clock(clock), .rst(rst), .csPin_n(csPin_n), .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n),
        .sdiPin(sdiPin), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .resultIn(resultIn), .channel(channel),
        .convBusy(convBusy)
    );
    asp_host_model i_host (
        .clock(clock), .sckOut(sckOut), .sckOe_n(sckOe_n), .sdoOut(sdoOut), .csPin_n(csPin_n),
        .sckIn(sckIn), .sdiPin(sdiPin)
    );

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // =====================================================================
    // Checks and waits
    task automatic check_word(input string what, input logic [20:0] exp, input logic [20:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic seen);
        check_word(what, {20'h00000, exp}, {20'h00000, seen});
    endtask : check_bit

    // Bounded wait; a hang ends the run
    task automatic wait_busy(input logic lvl, input int lim);
        int t;
        t = 0;
        while (convBusy !== lvl && t < lim) begin
            @(posedge clock);
            t++;
        end
        check_bit("convBusy wait", lvl, convBusy);
        if (convBusy !== lvl) stop_test();
    endtask : wait_busy

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // =====================================================================
    // Scenarios
    task automatic t_status();
        resultIn <= 18'h2a5c3;
        i_host.select(1'b1);
        repeat (8) @(posedge clock);
        check_bit("sdo enable", 1'b0, sdoOe_n);
        check_bit("sdo busy", 1'b1, sdoOut);
        wait_busy(1'b0, 400);
        repeat (4) @(posedge clock);
        check_bit("sdo done", 1'b0, sdoOut);
        i_host.deselect();
        check_bit("sdo release", 1'b1, sdoOe_n);
        repeat (40) @(posedge clock);
        check_bit("sleep", 1'b0, convBusy);
    endtask : t_status

    // Two pulses past the frame end while the next conversion runs
    task automatic t_frame();
        i_host.select(1'b1);
        repeat (8) @(posedge clock);
        i_host.xfer(21, 5'h16, got, per);
        check_word("ext frame", {1'b0, 18'h2a5c3, 2'b11}, got);
        check_bit("busy after frame", 1'b1, convBusy);
        check_bit("sck undriven", 1'b1, sckOe_n);
        check_word("channel", 21'h16, 21'(channel));
        i_host.deselect();
    endtask : t_frame

    task automatic t_abort();
        resultIn <= 18'h1b34e;
        wait_busy(1'b0, 400);
        i_host.select(1'b1);
        repeat (8) @(posedge clock);
        i_host.xfer(3, 5'h09, got, per);
        i_host.deselect();
        wait_busy(1'b1, 4);
        check_word("abort bits", 21'h1, got);
        check_word("channel kept", 21'h16, 21'(channel));
    endtask : t_abort

    // Pull-up at the select edge picks the device clock
    task automatic t_internal();
        resultIn <= 18'h0f0f5;
        i_host.select(1'b0);
        i_host.xfer(19, 5'h0b, got, per);
        check_word("int frame", {3'b000, 18'h0f0f5}, got);
        check_word("sck period", 21'(SCK_PER), 21'(per));
        repeat (12) @(posedge clock);
        check_bit("sck released", 1'b1, sckOe_n);
        check_bit("busy after int", 1'b1, convBusy);
        check_word("channel int", 21'h0b, 21'(channel));
        i_host.deselect();
    endtask : t_internal

    // Select stays low: conversions follow reads with no release
    task automatic t_continuous();
        i_host.select(1'b1);
        wait_busy(1'b0, 400);
        i_host.xfer(19, 5'h03, got, per);
        check_word("cont frame", {3'b000, 18'h0f0f5}, got);
        wait_busy(1'b1, 8);
        wait_busy(1'b0, 400);
        repeat (4) @(posedge clock);
        check_bit("cont done", 1'b0, sdoOut);
        check_word("channel cont", 21'h03, 21'(channel));
        i_host.deselect();
    endtask : t_continuous

    // Main sequence
    initial begin
        rst = 1'b1;
        resultIn = 18'h00000;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check_bit("reset oe", 1'b1, sdoOe_n);
        check_word("reset channel", 21'(asp_pkg::CHAN_RESET), 21'(channel));
        t_status();
        t_frame();
        t_abort();
        t_internal();
        t_continuous();
        stop_test();
    end

endmodule : tb_top

`default_nettype wire

// File: verilog/asp_edge_if.sv
// Edge events of the conditioned pins, passed from front end to controller.
// Assumes both ends run on the same clock.
`default_nettype none

interface asp_edge_if;
    logic csLow;        // Chip select asserted, synchronised
    logic csFall;       // One-cycle pulse on assertion
    logic csRise;       // One-cycle pulse on release
    logic sckLevel;     // Synchronised serial clock pin level
    logic sckRise;      // One-cycle pulse, rising serial clock
    logic sckFall;      // One-cycle pulse, falling serial clock
    logic sdiBit;       // Synchronised data input

    modport front (output csLow, csFall, csRise, sckLevel, sckRise, sckFall, sdiBit);
    modport ctrl  (input  csLow, csFall, csRise, sckLevel, sckRise, sckFall, sdiBit);
endinterface : asp_edge_if

`default_nettype wire

// File: verilog/asp_pin_sync.sv
// Synchronises chip select, serial clock and data input pins.
// Assumes pins are asynchronous to clock; produces edge pulses.
`default_nettype none

module asp_pin_sync (
    input  wire logic  clock,
    input  wire logic  rst,
    input  wire logic  csPin_n,
    input  wire logic  sckPin,
    input  wire logic  sdiPin,
    asp_edge_if.front  edges
);
    // =====================================================================
    // Two-stage synchronisers
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [2:0] prev;
    logic [2:0] next_stage1;
    logic [2:0] next_stage2;
    logic [2:0] next_prev;

    // Only the second stage and prev feed anything downstream
    always_comb begin
        next_stage1 = {sdiPin, sckPin, ~csPin_n};
        next_stage2 = stage1;
        next_prev   = stage2;
    end

    // Reset to idle: chip select released, clock high (pull-up)
    always_ff @(posedge clock) begin
        if (rst) begin
            stage1 <= 3'h2;
            stage2 <= 3'h2;
            prev   <= 3'h2;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            prev   <= next_prev;
        end
    end

    // Edge pulses from synchronised levels
    assign edges.csLow    = stage2[0];
    assign edges.csFall   = stage2[0] & ~prev[0];
    assign edges.csRise   = ~stage2[0] & prev[0];
    assign edges.sckLevel = stage2[1];
    assign edges.sckRise  = stage2[1] & ~prev[1];
    assign edges.sckFall  = ~stage2[1] & prev[1];
    assign edges.sdiBit   = stage2[2];

endmodule : asp_pin_sync

`default_nettype wire

// File: verilog/asp_pkg.sv
// Constants and types shared by the serial port of the converter.
// Assumes one 200 MHz clock domain and synchronous active-high reset.
`default_nettype none

package asp_pkg;

    // =====================================================================
    // Frame layout
    localparam int unsigned FRAME_BITS   = 19;      // Status flag plus result bits
    localparam int unsigned RESULT_BITS  = 18;      // Result word under the flag
    localparam int unsigned ADDR_BITS    = 5;       // Channel selection bits on the input line
    localparam int unsigned CNT_W        = 5;
    localparam logic [4:0]  LAST_EDGE    = 5'h13;   // Nineteenth edge of the frame
    localparam logic [4:0]  CHAN_RESET   = 5'h00;   // Channel after reset

    // =====================================================================
    // Timing
    localparam int unsigned SCK_DIV      = 8;       // Serial clock from conversion clock
    localparam int unsigned CLK_NS       = 5;       // Period of the system clock
    localparam int unsigned CONV_NS      = 2000;    // Conversion time, plain default
    localparam int unsigned CONV_CYCLES  = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CCLK_DIV     = 4;       // System clocks per conversion clock tick

    // =====================================================================
    // Port states, one-hot
    typedef enum logic [3:0] {
        ST_CONVERT = 4'h1,
        ST_SLEEP   = 4'h2,
        ST_OUTPUT  = 4'h4,
        ST_RESERVE = 4'h8
    } asp_state_t;

endpackage : asp_pkg

`default_nettype wire

// File: verilog/asp_serial_port.sv
// Serial port of a multi-channel converter: status, result readout, channel input.
// Assumes a conversion engine that supplies a result word; conversion end is timed internally over CONV_LEN cycles.
`default_nettype none

module asp_serial_port #(
    parameter int unsigned CONV_LEN = asp_pkg::CONV_CYCLES,
    parameter int unsigned ADDR_W   = asp_pkg::ADDR_BITS
) (
    input  wire logic                            clock,
    input  wire logic                            rst,
    input  wire logic                            csPin_n,
    input  wire logic                            sckIn,
    output logic                                 sckOut,
    output logic                                 sckOe_n,
    input  wire logic                            sdiPin,
    output logic                                 sdoOut,
    output logic                                 sdoOe_n,
    input  wire logic [asp_pkg::RESULT_BITS-1:0] resultIn,
    output logic [ADDR_W-1:0]                    channel,
    output logic                                 convBusy
);
    // =====================================================================
    // Pin conditioning
    asp_edge_if edges ();

    asp_pin_sync u_sync (
        .clock   (clock),
        .rst     (rst),
        .csPin_n (csPin_n),
        .sckPin  (sckIn),
        .sdiPin  (sdiPin),
        .edges   (edges)
    );

    // Serial clock as seen by the state logic: own generated edges, or pin edges in external mode
    logic intRise;
    logic intFall;
    logic anyRise;
    logic anyFall;

    // =====================================================================
    // Conversion clock divider and conversion timer
    logic [$clog2(asp_pkg::CCLK_DIV)-1:0] cclkCnt;
    logic [$clog2(asp_pkg::CCLK_DIV)-1:0] next_cclkCnt;
    logic                                 cclkTick;
    logic [$clog2(CONV_LEN+1)-1:0]        convCnt;
    logic [$clog2(CONV_LEN+1)-1:0]        next_convCnt;
    logic                                 convDone;

    // =====================================================================
    // Port state
    asp_pkg::asp_state_t             state;
    asp_pkg::asp_state_t             next_state;
    logic                            extMode;
    logic                            next_extMode;
    logic                            captured;
    logic                            next_captured;
    logic [asp_pkg::FRAME_BITS-1:0]  shiftOut;
    logic [asp_pkg::FRAME_BITS-1:0]  next_shiftOut;
    logic [ADDR_W-1:0]               shiftIn;
    logic [ADDR_W-1:0]               next_shiftIn;
    logic [ADDR_W-1:0]               next_channel;
    logic [asp_pkg::CNT_W-1:0]       riseCnt;
    logic [asp_pkg::CNT_W-1:0]       next_riseCnt;
    logic [asp_pkg::CNT_W-1:0]       fallCnt;
    logic [asp_pkg::CNT_W-1:0]       next_fallCnt;
    logic [2:0]                      sckDiv;
    logic [2:0]                      next_sckDiv;
    logic                            next_sckOut;
    logic                            next_sckOe_n;
    logic                            next_sdoOut;
    logic                            next_sdoOe_n;
    logic                            next_convBusy;
    logic                            startConv;

    // Conversion clock tick feeds the serial clock divider; the timer counts system clocks
    always_comb begin
        cclkTick     = (cclkCnt == '0);
        next_cclkCnt = cclkTick ? $bits(cclkCnt)'(asp_pkg::CCLK_DIV - 1) : cclkCnt - 1'b1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cclkCnt <= '0;
        end else begin
            cclkCnt <= next_cclkCnt;
        end
    end

    // Timer runs only while converting; reloaded on every start
    always_comb begin
        convDone     = (state == asp_pkg::ST_CONVERT) && (convCnt == '0);
        next_convCnt = convCnt;
        if (startConv) begin
            next_convCnt = $bits(convCnt)'(CONV_LEN);
        end else if (state == asp_pkg::ST_CONVERT && convCnt != '0) begin
            next_convCnt = convCnt - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            convCnt <= $bits(convCnt)'(CONV_LEN);
        end else begin
            convCnt <= next_convCnt;
        end
    end

    // =====================================================================
    // Serial clock edges from the active source
    // Internal clock toggles every four conversion ticks: period of eight ticks
    always_comb begin
        intRise = 1'b0;
        intFall = 1'b0;
        if (!extMode && state == asp_pkg::ST_OUTPUT && cclkTick && sckDiv == 3'h3) begin
            intRise = ~sckOut && (fallCnt != asp_pkg::LAST_EDGE);
            intFall = sckOut;
        end
        anyRise = extMode ? edges.sckRise : intRise;
        anyFall = extMode ? edges.sckFall : intFall;
    end

    // =====================================================================
    // Main sequencer
    always_comb begin
        next_state    = state;
        next_extMode  = extMode;
        next_captured = captured;
        next_shiftOut = shiftOut;
        next_shiftIn  = shiftIn;
        next_channel  = channel;
        next_riseCnt  = riseCnt;
        next_fallCnt  = fallCnt;
        next_sckDiv   = sckDiv;
        next_sckOut   = sckOut;
        next_sckOe_n  = sckOe_n;
        next_sdoOut   = sdoOut;
        startConv     = 1'b0;

        // Source chosen on each chip-select fall: low clock pin means external
        if (edges.csFall) begin
            next_extMode = ~edges.sckLevel;
        end

        case (state)
            asp_pkg::ST_CONVERT: begin
                next_sdoOut = 1'b1;                                         // Flag high while busy
                if (convDone) begin
                    // Result frozen in the shift register, flag bit low
                    next_shiftOut = {1'b0, resultIn};
                    next_sdoOut   = 1'b0;
                    next_state    = asp_pkg::ST_SLEEP;                      // Always sleeps first, even while selected
                end
            end
            asp_pkg::ST_SLEEP: begin
                next_sdoOut  = 1'b0;                                        // Low before capture starts
                next_riseCnt = '0;                                          // Fresh counters each frame
                next_fallCnt = '0;
                next_sckDiv  = '0;
                next_captured = 1'b0;
                if (!extMode && edges.csLow) begin
                    next_state = asp_pkg::ST_OUTPUT;                        // Internal clock starts at once
                end else if (extMode && edges.csLow && edges.sckRise) begin
                    // First rising edge wakes the port and captures bit one
                    next_state   = asp_pkg::ST_OUTPUT;
                    next_riseCnt = 5'h01;
                    next_shiftIn = {shiftIn[ADDR_W-2:0], edges.sdiBit};
                end
            end
            asp_pkg::ST_OUTPUT: begin
                if (!extMode && cclkTick) begin
                    next_sckDiv = (sckDiv == 3'h3) ? 3'h0 : sckDiv + 3'h1;
                end
                if (intRise) begin
                    next_sckOut = 1'b1;
                end else if (intFall) begin
                    next_sckOut = 1'b0;
                end
                // Capture on rising edges only, input counted once per edge
                if (anyRise && riseCnt < asp_pkg::LAST_EDGE) begin
                    next_riseCnt = riseCnt + 5'h01;
                    if (riseCnt < 5'(ADDR_W)) begin
                        next_shiftIn = {shiftIn[ADDR_W-2:0], edges.sdiBit};
                    end
                    if (riseCnt == 5'(ADDR_W - 1)) begin
                        next_captured = 1'b1;                               // Last address bit in
                    end
                end
                // Shift on falling edges; flag is the first bit already on the line
                if (anyFall && fallCnt < asp_pkg::LAST_EDGE) begin
                    next_fallCnt  = fallCnt + 5'h01;
                    next_shiftOut = {shiftOut[asp_pkg::FRAME_BITS-2:0], 1'b0};
                    next_sdoOut   = shiftOut[asp_pkg::FRAME_BITS-2];
                    if (fallCnt == asp_pkg::LAST_EDGE - 5'h01) begin
                        // Nineteenth fall: new conversion, flag high
                        next_sdoOut = 1'b1;
                        next_sckOut = 1'b1;
                        startConv   = 1'b1;
                        next_state  = asp_pkg::ST_CONVERT;
                    end
                end
                // Deselect mid-transfer aborts; counts past the frame are ignored
                if (edges.csRise) begin
                    startConv   = 1'b1;
                    next_state  = asp_pkg::ST_CONVERT;
                    next_sdoOut = 1'b1;
                    next_sckOut = 1'b1;
                end
            end
            default: begin
                next_state = asp_pkg::ST_CONVERT;
                startConv  = 1'b1;
            end
        endcase

        // Channel only takes a fully received address
        if (startConv && (next_captured || captured)) begin
            next_channel = next_shiftIn;
        end
        if (startConv) begin
            next_captured = 1'b0;
        end

        // Clock pin driven only in internal mode while outputting
        next_sckOe_n = ~(!next_extMode && edges.csLow && next_state == asp_pkg::ST_OUTPUT);
        if (!next_extMode && edges.csLow && next_state == asp_pkg::ST_SLEEP) begin
            next_sckOut = 1'b0;                                             // Pulled low during status test
        end
    end

    // Output enable follows chip select alone
    always_comb begin
        next_sdoOe_n  = ~edges.csLow;
        next_convBusy = (next_state == asp_pkg::ST_CONVERT);
    end

    // Registers; reset starts a conversion, internal source as after power-up
    always_ff @(posedge clock) begin
        if (rst) begin
            state    <= asp_pkg::ST_CONVERT;
            extMode  <= 1'b0;
            captured <= 1'b0;
            shiftOut <= '0;
            shiftIn  <= '0;
            channel  <= asp_pkg::CHAN_RESET[ADDR_W-1:0];
            riseCnt  <= '0;
            fallCnt  <= '0;
            sckDiv   <= '0;
            sckOut   <= 1'b1;
            sckOe_n  <= 1'b1;
            sdoOut   <= 1'b1;
            sdoOe_n  <= 1'b1;
            convBusy <= 1'b1;
        end else begin
            state    <= next_state;
            extMode  <= next_extMode;
            captured <= next_captured;
            shiftOut <= next_shiftOut;
            shiftIn  <= next_shiftIn;
            channel  <= next_channel;
            riseCnt  <= next_riseCnt;
            fallCnt  <= next_fallCnt;
            sckDiv   <= next_sckDiv;
            sckOut   <= next_sckOut;
            sckOe_n  <= next_sckOe_n;
            sdoOut   <= next_sdoOut;
            sdoOe_n  <= next_sdoOe_n;
            convBusy <= next_convBusy;
        end
    end

    // Power-up strap: the first state after reset is a conversion, whose start
    // re-reads the source on the next chip-select fall; no pin is sampled in reset.

endmodule : asp_serial_port

`default_nettype wire
